// ---- design/flr_recorder.sv ----
`timescale 1ns/100ps
module flr_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ov_q, ov_d;
    logic [W-1:0] od_q, od_d;
    logic push, pop;
    assign in_ready = cnt_q < CNT_FULL;
    assign push = in_valid && in_ready;
    assign pop = ov_q && out_ready;
    assign out_valid = ov_q;
    assign out_data = od_q;
    always_comb begin
        wr_d = wr_q + AW'(push);
        rd_d = rd_q + AW'(pop);
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        ov_d = cnt_d != '0;
        // Head slot written this cycle bypasses the array
        od_d = (push && wr_q == rd_d) ? in_data : mem[rd_d];
    end
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end
endmodule // flr_fifo

module flr_recorder #(
    parameter int TICK_CYC = flr_pkg::TICK_CYC,
    parameter logic [7:0] PREFACE0 = 8'h46, // Arbitrary value
    parameter logic [7:0] PREFACE1 = 8'h4C // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic tel_pass,
    input wire flr_pkg::flr_page_t tel_page,
    input wire logic [15:0] status_word,
    input wire logic [79:0] hdr_extra,
    input wire logic fault_det,
    input wire logic [7:0] fault_src,
    input wire logic signed [9:0] die_temp,
    input wire logic [15:0] global_config_word,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    output logic cmd_busy,
    input wire logic vstat_clr,
    output logic [7:0] vendor_status_byte,
    output logic nv_req,
    output flr_pkg::flr_nv_t nv_cmd,
    input wire logic nv_ack,
    input wire logic [7:0] nv_rdata,
    output logic rec_valid,
    output logic [7:0] rec_data,
    input wire logic rec_ready
);
    import flr_pkg::*;
    flr_ctl_t c_q, c_d;
    flr_page_t evt_q [EVT_NUM];
    logic evt_we, f_in_rdy, can_push, has_rec, trig, force_cmd;

    function automatic logic [7:0] hb(input logic [15:0] w, input logic lo);
        return lo ? w[7:0] : w[15:8];
    endfunction

    function automatic logic [7:0] rec_byte(input logic [7:0] i);
        int k, e, b, slot;
        flr_page_t pg;
        k = int'(i);
        e = (k - HDR_LEN) / EVT_LEN;
        b = (k - HDR_LEN) % EVT_LEN;
        slot = (int'(c_q.wp) + EVT_NUM - 1 - e) % EVT_NUM;
        pg = evt_q[slot];
        if (k == 0) return PREFACE0;
        if (k == 1) return PREFACE1;
        if (k < B_SRC) return hb(c_q.sw, k == B_SRC - 1);
        if (k == B_SRC) return c_q.src;
        if (k < B_VPK0) return c_q.tsc[8 * (k - B_TS) +: 8];
        if (k < B_VPK1) return hb(c_q.vpk0, k == B_VPK0 + 1);
        if (k < B_IPK0) return hb(c_q.vpk1, k == B_VPK1 + 1);
        if (k < B_EXT) return hb(c_q.ipk0, k == B_IPK0 + 1);
        if (k < HDR_LEN) return c_q.ext[8 * (HDR_LEN - 1 - k) +: 8];
        return pg[8 * (EVT_LEN - 1 - b) +: 8];
    endfunction

    // Events five and six are not kept in storage; event four stands in
    function automatic logic [7:0] nv_map(input logic [7:0] i);
        int k;
        k = int'(i);
        return (k < NV_LEN) ? i : 8'(NV_EVT4 + (k - NV_LEN) % EVT_LEN);
    endfunction

    flr_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(c_q.push_v),
        .in_data(c_q.push_d),
        .in_ready(f_in_rdy),
        .out_valid(rec_valid),
        .out_data(rec_data),
        .out_ready(rec_ready)
    );

    assign can_push = !c_q.push_v || f_in_rdy;
    assign has_rec = c_q.frozen || c_q.locked;
    assign force_cmd = c_q.st == S_IDLE && cmd_valid && cmd_code == CMD_FORCE;
    assign trig = (fault_det && global_config_word[CFG_LOG_EN]) || force_cmd;
    assign cmd_busy = c_q.busy;
    assign vendor_status_byte = c_q.vstat;
    assign nv_req = c_q.nvreq;
    assign nv_cmd = c_q.nvc;

    always_comb begin
        c_d = c_q;
        evt_we = 1'b0;
        if (c_q.push_v && f_in_rdy) c_d.push_v = 1'b0;
        if (c_q.nvreq && nv_ack) c_d.nvreq = 1'b0;
        if (c_q.tick == 15'(TICK_CYC - 1)) begin
            c_d.tick = '0;
            c_d.ts = c_q.ts + 48'h0000_0000_0001;
        end else begin
            c_d.tick = c_q.tick + 15'h0001;
        end
        if (die_temp > HOT_ON_C) c_d.hot = 1'b1;
        else if (die_temp < HOT_OFF_C) c_d.hot = 1'b0;
        if (vstat_clr) c_d.vstat[VSTAT_SAVED] = 1'b0;
        if (force_cmd && global_config_word[CFG_LOG_EN]) c_d.vstat[VSTAT_SAVED] = 1'b1;
        if (trig && !c_q.locked && !c_q.frozen && !c_q.pend) begin
            c_d.pend = 1'b1;
            c_d.src = force_cmd ? FORCE_SRC : fault_src;
            c_d.tsc = c_q.ts;
        end
        // Peaks belong to a frozen record until it is released
        if (cmd_valid && cmd_code == CMD_PEAK && !c_q.frozen) begin
            c_d.vpk0 = '0;
            c_d.vpk1 = '0;
            c_d.ipk0 = '0;
        end
        // Early faults may capture pages not yet refreshed
        if (tel_pass && !c_q.frozen) begin
            evt_we = 1'b1;
            c_d.wp = (c_q.wp == 3'(EVT_NUM - 1)) ? 3'h0 : c_q.wp + 3'h1;
            if (tel_page.vout0 > c_d.vpk0) c_d.vpk0 = tel_page.vout0;
            if (tel_page.vout1 > c_d.vpk1) c_d.vpk1 = tel_page.vout1;
            if (tel_page.iout0 > c_d.ipk0) c_d.ipk0 = tel_page.iout0;
            c_d.sw = status_word;
            c_d.ext = hdr_extra;
            if (c_q.pend) begin
                c_d.pend = 1'b0;
                c_d.frozen = 1'b1;
                c_d.save = 1'b1;
            end
        end
        unique case (c_q.st)
            S_BOOT: begin
                if (nv_ack) begin
                    c_d.locked = nv_rdata == LOCK_MARK;
                    c_d.st = S_IDLE;
                end
            end
            S_IDLE: begin
                if (c_q.save && !c_q.hot) begin
                    c_d.st = S_SAVE;
                    c_d.idx = '0;
                    c_d.nvreq = 1'b1;
                    c_d.nvc = '{we: 1'b1, addr: 8'h00, wdata: rec_byte(8'h00)};
                end else if (cmd_valid && cmd_code == CMD_ERASE && !c_q.hot) begin
                    c_d.st = S_ERASE;
                    c_d.nvreq = 1'b1;
                    c_d.nvc = '{we: 1'b1, addr: NV_LOCK_ADDR, wdata: 8'h00};
                end else if (cmd_valid && cmd_code == CMD_READ) begin
                    c_d.st = S_RDLEN;
                end
            end
            S_SAVE: begin
                if (nv_ack) begin
                    c_d.nvreq = 1'b1;
                    if (c_q.idx == 8'(NV_LEN - 1)) begin
                        c_d.st = S_LOCK;
                        c_d.nvc = '{we: 1'b1, addr: NV_LOCK_ADDR, wdata: LOCK_MARK};
                    end else begin
                        c_d.idx = c_q.idx + 8'h01;
                        c_d.nvc = '{we: 1'b1, addr: c_d.idx, wdata: rec_byte(c_d.idx)};
                    end
                end
            end
            S_LOCK: begin
                if (nv_ack) begin
                    c_d.locked = 1'b1;
                    c_d.save = 1'b0;
                    c_d.st = S_IDLE;
                end
            end
            S_ERASE: begin
                if (nv_ack) begin
                    c_d.locked = 1'b0;
                    c_d.frozen = 1'b0;
                    c_d.save = 1'b0;
                    c_d.pend = 1'b0;
                    c_d.st = S_IDLE;
                end
            end
            S_RDLEN: begin
                if (can_push) begin
                    c_d.push_v = 1'b1;
                    c_d.push_d = has_rec ? 8'(REC_LEN) : 8'h00;
                    c_d.idx = '0;
                    if (!has_rec) begin
                        c_d.st = S_IDLE;
                    end else if (c_q.frozen) begin
                        c_d.st = S_RDRAM;
                    end else begin
                        c_d.st = S_RDNV;
                        c_d.nvreq = 1'b1;
                        c_d.nvc = '{we: 1'b0, addr: nv_map(8'h00), wdata: 8'h00};
                    end
                end
            end
            S_RDRAM: begin
                if (can_push) begin
                    c_d.push_v = 1'b1;
                    c_d.push_d = rec_byte(c_q.idx);
                    c_d.idx = c_q.idx + 8'h01;
                    if (c_q.idx == 8'(REC_LEN - 1)) c_d.st = S_IDLE;
                end
            end
            S_RDNV: begin
                if (nv_ack) begin
                    c_d.rdb = nv_rdata;
                    c_d.st = S_RDPUSH;
                end
            end
            S_RDPUSH: begin
                if (can_push) begin
                    c_d.push_v = 1'b1;
                    c_d.push_d = c_q.rdb;
                    c_d.idx = c_q.idx + 8'h01;
                    if (c_q.idx == 8'(REC_LEN - 1)) begin
                        c_d.st = S_IDLE;
                    end else begin
                        c_d.st = S_RDNV;
                        c_d.nvreq = 1'b1;
                        c_d.nvc = '{we: 1'b0, addr: nv_map(c_d.idx), wdata: 8'h00};
                    end
                end
            end
            default: c_d.st = S_IDLE;
        endcase
        c_d.busy = c_d.st != S_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (evt_we) begin
            evt_q[c_q.wp] <= tel_page;
        end
        if (!nrst) begin
            c_q <= CTL_RST;
        end else begin
            c_q <= c_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    refresh_ring_a: assert property (
        tel_pass && !c_q.frozen |=> c_q.wp != $past(c_q.wp))
        else $error("ring pointer did not advance on a pass");
    freeze_save_a: assert property (
        c_q.pend && tel_pass && !c_q.frozen |=> c_q.frozen && c_q.save)
        else $error("pass with pending fault did not freeze record");
    lock_set_a: assert property (
        c_q.st == S_LOCK && nv_ack |=> c_q.locked && c_q.st == S_IDLE)
        else $error("lock not set after lock write");
    len_zero_a: assert property (
        c_q.st == S_RDLEN && can_push && !has_rec |=> c_q.push_v && c_q.push_d == 8'h00
        && c_q.st == S_IDLE)
        else $error("empty log length not zero");
    len_full_a: assert property (
        c_q.st == S_RDLEN && can_push && has_rec |=> c_q.push_d == 8'(REC_LEN))
        else $error("record length not 147");
    nv_keep_a: assert property (
        c_q.locked && c_q.nvreq && c_q.nvc.we |-> c_q.nvc.addr == NV_LOCK_ADDR
        && c_q.nvc.wdata == 8'h00)
        else $error("locked log written other than by erase");
    nv_mirror_a: assert property (
        c_q.st == S_RDNV && c_q.idx >= 8'(NV_LEN) |-> c_q.nvc.addr >= 8'(NV_EVT4)
        && c_q.nvc.addr < 8'(NV_LEN))
        else $error("late event not mapped onto event four");
    force_flag_a: assert property (
        force_cmd && global_config_word[CFG_LOG_EN] |=> vendor_status_byte[VSTAT_SAVED])
        else $error("force save did not raise vendor status bit");
    hot_hold_a: assert property (
        c_q.st == S_IDLE && c_q.hot |=> c_q.st != S_SAVE)
        else $error("save started while die hot");
    save_done_c: cover property (c_q.st == S_LOCK ##1 c_q.locked);
    read_ram_c: cover property (c_q.st == S_RDRAM && c_q.idx == 8'(REC_LEN - 1));
    read_nv_c: cover property (c_q.st == S_RDPUSH && c_q.idx == 8'(REC_LEN - 1));
    erase_c: cover property (c_q.st == S_ERASE && nv_ack);
endmodule // flr_recorder

// ---- design/flr_pkg.sv ----
package flr_pkg;
// Functional notes
// - While running, keep refreshing the RAM record with status, telemetry and peaks.
// - On a fault, copy the RAM record into the non-volatile log area.
// - After a save, lock the log so later faults cannot overwrite it.
// - Log read with no record answers a length byte of zero, nothing else.
// - Log read with a record always answers exactly 147 payload bytes.
// - Saved record survives power loss; only the erase command removes it.
// - RAM reads give six events; non-volatile reads repeat event four twice.
// - Faults in the first second may leave early pages invalid; readers tolerate.
// - Force-save runs the same save sequence as a real fault.
// - Force-save with config bit 7 set raises bit 3 of vendor status.
// - Above 130 C keep the record in RAM; write it once below 125 C.
// - Force-save is a send-byte command with no data bytes.
// - The log is read-only, read as a block led by its length byte.
// - Bytes 0-1 ASCII preface, bytes 2-3 register word, byte 4 source.
// - Bytes 5-10 hold the 48-bit 200 us timestamp, low byte first.
// - Bytes 11-12 hold channel 0 peak output voltage, high byte first.
// - Bytes 13-14 hold channel 1 peak output voltage, high byte first.
// - Bytes 15-16 hold channel 0 peak output current, high byte first.
// - LIN16 fields carry the 16-bit mantissa only.
// - Erase command initialises the log area and unlocks it; the code only writes 00 to the lock byte at NV_LOCK_ADDR.
// - Each event is one full telemetry pass current at the fault.
localparam int REC_LEN = 147;
localparam int HDR_LEN = 27;
localparam int EVT_LEN = 20;
localparam int EVT_NUM = 6;
localparam int NV_EVTS = 4;
localparam int NV_LEN = HDR_LEN + NV_EVTS * EVT_LEN;
localparam int NV_EVT4 = HDR_LEN + (NV_EVTS - 1) * EVT_LEN;
localparam int B_SRC = 4;
localparam int B_TS = 5;
localparam int B_VPK0 = 11;
localparam int B_VPK1 = 13;
localparam int B_IPK0 = 15;
localparam int B_EXT = 17;
localparam logic [7:0] NV_LOCK_ADDR = 8'(NV_LEN);
localparam logic [7:0] LOCK_MARK = 8'hA5;
localparam logic [7:0] CMD_READ = 8'hEE;
localparam logic [7:0] CMD_FORCE = 8'hEA;
localparam logic [7:0] CMD_ERASE = 8'hEC;
localparam logic [7:0] CMD_PEAK = 8'hE3;
localparam logic [7:0] FORCE_SRC = 8'hFF;
localparam int CFG_LOG_EN = 7;
localparam int VSTAT_SAVED = 3;
localparam logic signed [9:0] HOT_ON_C = 10'sh082;
localparam logic signed [9:0] HOT_OFF_C = 10'sh07D;
localparam int CLK_NS = 10;
localparam int TICK_NS = 200000;
localparam int TICK_CYC = TICK_NS / CLK_NS;
localparam int FIFO_DEPTH = 32;
typedef enum logic [3:0] {
    S_BOOT, S_IDLE, S_SAVE, S_LOCK, S_ERASE, S_RDLEN, S_RDRAM, S_RDNV, S_RDPUSH
} flr_state_t;
typedef struct packed {
    logic [15:0] vout0;
    logic [15:0] vout1;
    logic [15:0] iout0;
    logic [111:0] rest;
} flr_page_t;
typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
} flr_nv_t;
typedef struct packed {
    flr_state_t st;
    logic [7:0] idx;
    logic locked, frozen, pend, save, hot, busy, nvreq, push_v;
    logic [7:0] src, vstat, push_d, rdb;
    logic [47:0] tsc, ts;
    logic [14:0] tick;
    logic [15:0] vpk0, vpk1, ipk0, sw;
    logic [79:0] ext;
    logic [2:0] wp;
    flr_nv_t nvc;
} flr_ctl_t;
localparam flr_ctl_t CTL_RST = '{st: S_BOOT, nvreq: 1'b1, busy: 1'b1,
    nvc: '{we: 1'b0, addr: NV_LOCK_ADDR, wdata: 8'h00}, default: '0};
endpackage

// ---- tb/flr_nv_model.sv ----
`timescale 1ns/100ps
module flr_nv_model (
    input wire logic sys_clk,
    input wire logic nv_req,
    input wire flr_pkg::flr_nv_t nv_cmd,
    output logic nv_ack,
    output logic [7:0] nv_rdata
);
    import flr_pkg::*;
    logic [7:0] mem [0:255];
    int n_wr = 0;
    int cnt = 0;
    logic slow = 1'b0;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // Storage has no reset; answers alternate between prompt and slow
    always @(posedge sys_clk) begin
        nv_rdata <= ~nv_rdata;
        nv_ack <= 1'b0;
        if (nv_req && !nv_ack) begin
            if (cnt >= (slow ? 3 : 0)) begin
                nv_ack <= 1'b1;
                cnt <= 0;
                slow <= ~slow;
                if (nv_cmd.we) begin
                    mem[nv_cmd.addr] <= nv_cmd.wdata;
                    n_wr <= n_wr + 1;
                end else begin
                    nv_rdata <= mem[nv_cmd.addr];
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // flr_nv_model

// ---- tb/flr_testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import flr_pkg::*;
    localparam int TK = 4;
    logic sys_clk, nrst, tel_pass, fault_det, cmd_valid, cmd_busy, vstat_clr;
    logic nv_req, nv_ack, rec_valid, rec_ready;
    flr_page_t tel_page;
    flr_nv_t nv_cmd;
    logic [15:0] status_word, global_config_word;
    logic [79:0] hdr_extra;
    logic [7:0] fault_src, cmd_code, vendor_status_byte, nv_rdata, rec_data;
    logic signed [9:0] die_temp;
    logic [7:0] rb [0:147];
    logic [7:0] ram_rec [0:147];
    int n_fail = 0, n_compared = 0, cyc = 0, t_fault = 0;

    flr_recorder #(.TICK_CYC(TK), .PREFACE0(8'h51), .PREFACE1(8'h52)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .tel_pass(tel_pass), .tel_page(tel_page),
        .status_word(status_word), .hdr_extra(hdr_extra), .fault_det(fault_det),
        .fault_src(fault_src), .die_temp(die_temp), .global_config_word(global_config_word),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_busy(cmd_busy), .vstat_clr(vstat_clr),
        .vendor_status_byte(vendor_status_byte), .nv_req(nv_req), .nv_cmd(nv_cmd),
        .nv_ack(nv_ack), .nv_rdata(nv_rdata), .rec_valid(rec_valid), .rec_data(rec_data),
        .rec_ready(rec_ready));
    flr_nv_model nv (.sys_clk(sys_clk), .nv_req(nv_req), .nv_cmd(nv_cmd), .nv_ack(nv_ack),
        .nv_rdata(nv_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= nrst ? cyc + 1 : 0;

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Peaks of every field fall on page 5 of a 1..9 run
    function automatic flr_page_t page(input int k);
        int m = k * (10 - k);
        return '{vout0: 16'h1000 + 16'(m), vout1: 16'h2000 + 16'(2 * m),
            iout0: 16'h0300 + 16'(3 * m), rest: {14{8'(k)}}};
    endfunction

    task do_reset;
        nrst = 1'b0;
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
    endtask

    task wait_idle;
        int i;
        repeat (4) @(negedge sys_clk);
        for (i = 0; i < 3000 && cmd_busy !== 1'b0; i++) @(negedge sys_clk);
        chk("cmd_busy", 0, cmd_busy);
    endtask

    task send_cmd(input logic [7:0] code);
        wait_idle();
        cmd_valid = 1'b1;
        cmd_code = code;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask

    task tel_step(input int k);
        tel_page = page(k);
        status_word = 16'hAB00 + 16'(k);
        hdr_extra = {10{8'h40 + 8'(k)}};
        tel_pass = 1'b1;
        @(negedge sys_clk);
        tel_pass = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task fault(input logic [7:0] src);
        fault_det = 1'b1;
        fault_src = src;
        t_fault = cyc;
        @(negedge sys_clk);
        fault_det = 1'b0;
    endtask

    // Sink stalls 45 cycles, enough to fill the FIFO on RAM reads, then takes two bytes in three
    task read_rec;
        int n, t;
        n = 0;
        send_cmd(CMD_READ);
        for (t = 0; t < 8000; t++) begin
            if (n > 0 && n > int'(rb[0])) break;
            if (rec_valid === 1'b1 && t >= 45 && t % 3 != 0) begin
                rb[n] = rec_data;
                n++;
                rec_ready = 1'b1;
            end else begin
                rec_ready = 1'b0;
            end
            @(negedge sys_clk);
        end
        rec_ready = 1'b0;
        chk("bytes read", (n > 0) ? 1 + int'(rb[0]) : 1, n);
        repeat (5) @(negedge sys_clk);
        chk("no extra bytes", 0, rec_valid);
    endtask

    task chk_hdr(input logic [7:0] src, input int k, input int m);
        chk("length", 147, rb[0]);
        chk("preface", 16'h5152, {rb[1], rb[2]});
        chk("status word", 16'hAB00 + 16'(k), {rb[3], rb[4]});
        chk("source", src, rb[5]);
        chk("peak vout0", 16'h1000 + 16'(m), {rb[12], rb[13]});
        chk("peak vout1", 16'h2000 + 16'(2 * m), {rb[14], rb[15]});
        chk("peak iout0", 16'h0300 + 16'(3 * m), {rb[16], rb[17]});
    endtask

    task s_empty;
        read_rec();
        chk("empty length", 0, rb[0]);
    endtask

    task s_capture;
        flr_page_t p;
        logic [47:0] ts;
        int e, j, w;
        w = nv.n_wr;
        for (e = 1; e <= 8; e++) tel_step(e);
        fault(8'h5C);
        tel_step(9);
        wait_idle();
        chk("writes per save", w + NV_LEN + 1, nv.n_wr);
        chk("lock byte", LOCK_MARK, nv.mem[NV_LEN]);
        read_rec();
        chk_hdr(8'h5C, 9, 25);
        for (e = 0; e < 6; e++) begin
            p = page(9 - e);
            for (j = 0; j < 20; j++) begin
                chk("event", p[159 - 8 * j -: 8], rb[28 + 20 * e + j]);
            end
        end
        ts = {rb[11], rb[10], rb[9], rb[8], rb[7], rb[6]};
        chk("timestamp", 1, ts + 3 >= t_fault / TK && ts <= t_fault / TK + 3);
        ram_rec = rb;
    endtask

    task s_reload;
        int b, s;
        do_reset();
        read_rec();
        chk("nv length", 147, rb[0]);
        for (b = 0; b < REC_LEN; b++) begin
            s = (b < NV_LEN) ? b : NV_EVT4 + (b - NV_LEN) % EVT_LEN;
            chk("nv byte", ram_rec[s + 1], rb[b + 1]);
        end
    endtask

    task s_locked;
        int w, k;
        w = nv.n_wr;
        for (k = 1; k <= 3; k++) tel_step(k);
        fault(8'h33);
        tel_step(4);
        send_cmd(CMD_FORCE);
        wait_idle();
        chk("writes while locked", w, nv.n_wr);
        chk("status while locked", 1, vendor_status_byte[VSTAT_SAVED]);
        vstat_clr = 1'b1;
        @(negedge sys_clk);
        vstat_clr = 1'b0;
        read_rec();
        chk("kept source", 8'h5C, rb[5]);
    endtask

    task s_erase;
        int w;
        send_cmd(CMD_ERASE);
        wait_idle();
        chk("erased lock", 8'h00, nv.mem[NV_LEN]);
        // A fault with logging switched off must not start a capture
        global_config_word = 16'h0000;
        w = nv.n_wr;
        fault(8'h11);
        tel_step(1);
        global_config_word = 16'h0080;
        wait_idle();
        chk("writes with logging off", w, nv.n_wr);
        read_rec();
        chk("erased length", 0, rb[0]);
    endtask

    task s_force_hot;
        int w, k;
        send_cmd(CMD_PEAK);
        for (k = 1; k <= 3; k++) tel_step(k);
        die_temp = 10'sh083;
        w = nv.n_wr;
        chk("status before force", 0, vendor_status_byte[VSTAT_SAVED]);
        send_cmd(CMD_FORCE);
        tel_step(3);
        repeat (50) @(negedge sys_clk);
        chk("status saved bit", 1, vendor_status_byte[VSTAT_SAVED]);
        chk("writes while hot", w, nv.n_wr);
        die_temp = 10'sh07C;
        wait_idle();
        chk("writes after cooling", w + NV_LEN + 1, nv.n_wr);
        read_rec();
        chk_hdr(FORCE_SRC, 3, 21);
        vstat_clr = 1'b1;
        @(negedge sys_clk);
        vstat_clr = 1'b0;
        @(negedge sys_clk);
        chk("status cleared", 0, vendor_status_byte[VSTAT_SAVED]);
    endtask

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {tel_pass, fault_det, cmd_valid, vstat_clr, rec_ready} = '0;
        tel_page = page(0);
        status_word = 16'h0000;
        hdr_extra = '0;
        fault_src = 8'h00;
        cmd_code = 8'h00;
        die_temp = 10'sh028;
        global_config_word = 16'h0080;
        do_reset();
        s_empty();
        s_capture();
        s_reload();
        s_locked();
        s_erase();
        s_force_hot();
        tally_and_finish();
    end
endmodule // testbench
